// >>> bench/asr_remote_tx.sv
// remote serial transmitter that drives the receive line of the port
// assumes 16 system clocks of 20 ns per bit, i.e. a divisor of zero with the high-speed bit set
`timescale 1ns/10ps
`default_nettype none
module asr_remote_tx (
  output var logic line
);
  // ****
  // line driver
  // ****
  localparam int BIT_NS = 320;
  logic inv = 1'h0;
  initial line = 1'h1;
  // bit edges fall on clock edges, so the line changes after the design samples
  task automatic set_inv(input logic i);
    inv = i;
    line <= ~i;
  endtask : set_inv
  task automatic send(input logic [8:0] d, input logic nine, input logic stop);
    line <= inv;
    #(BIT_NS);
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      line <= d[i] ^ inv;
      #(BIT_NS);
    end
    // a low stop level is how a framing error is provoked
    line <= stop ^ inv;
    #(BIT_NS);
    line <= ~inv;
  endtask : send
  task automatic glitch(input int ns);
    line <= inv;
    #(ns);
    line <= ~inv;
  endtask : glitch
endmodule : asr_remote_tx
`default_nettype wire

// >>> bench/asr_serial_port_asserts.sv
// bus-side assertions for the serial port
// assumes it is bound to asr_serial_port and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module asr_serial_port_asserts
  import asr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [5:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [5:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ****
  // assertions
  // ****
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_b_busy;
    BVALID |-> !AWREADY && !WREADY;
  endproperty
  a_b_busy: assert property (p_b_busy)
    else $error("write accepted while response pending");
  property p_w_answer;
    AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write response late");
  property p_w_unmapped;
    AWVALID && AWREADY && WVALID && WREADY && AWADDR > 6'h20
      |-> ##[1:2] (BVALID && BRESP == ASR_RESP_SLVERR);
  endproperty
  a_w_unmapped: assert property (p_w_unmapped)
    else $error("unmapped write not refused");
  property p_r_answer;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while stalled");
  property p_r_unmapped;
    ARVALID && ARREADY && ARADDR > 6'h20 |=> RRESP == ASR_RESP_SLVERR && RDATA == 32'h0;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped)
    else $error("unmapped read not refused");
  property p_r_narrow;
    RVALID |-> RDATA[31:8] == 24'h0;
  endproperty
  a_r_narrow: assert property (p_r_narrow)
    else $error("upper read bits not zero");
endmodule : asr_serial_port_asserts
bind asr_serial_port asr_serial_port_asserts u_asr_serial_port_asserts (.CLOCK(CLOCK),
  .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY));
`default_nettype wire

// >>> bench/test_asr_serial_port.sv
// self-checking bench: register table rows, then receive cases
// assumes asr_remote_tx sends at 16 clocks per bit
`timescale 1ns/10ps
`default_nettype none
module test_asr_serial_port
  import asr_pkg::*;
;
  typedef struct packed {logic [5:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} asr_row_t;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_line, tx_out, tx_oe, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] val;
  int errors = 0, num_checks = 0;
  asr_row_t rows [6] = '{
    '{ASR_OFF_INTERRUPT_CONTROL, 1'h0, 8'h00, 8'h00, ASR_RESP_OKAY},
    '{ASR_OFF_BAUD_DIVISOR_HIGH, 1'h1, 8'hA5, 8'hA5, ASR_RESP_OKAY},
    '{ASR_OFF_INTERRUPT_CONTROL, 1'h1, 8'hFF, 8'hF0, ASR_RESP_OKAY},
    '{ASR_OFF_RX_STATUS_CONTROL, 1'h1, 8'h57, 8'h50, ASR_RESP_OKAY},
    '{ASR_OFF_FLAGS, 1'h1, 8'hFF, 8'h00, ASR_RESP_OKAY},
    '{6'h24, 1'h1, 8'h11, 8'h00, ASR_RESP_SLVERR}};
  asr_serial_port u_asr_serial_port (.CLOCK(clock), .RST(rst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'h1), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .RX_PIN(rx_line), .TX_PIN_OUT(tx_out), .TX_PIN_OE(tx_oe),
    .INT_REQUEST(irq));
  asr_remote_tx u_line (.line(rx_line));
  always #10 clock = ~clock;
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clock); while (!bvalid);
    bready <= 1'h0;
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'h0;
    // one stalled cycle so the read data must be held
    @(posedge clock);
    rready <= 1'h1;
    do @(posedge clock); while (!rvalid);
    rready <= 1'h0;
    val = rdata[7:0];
    resp = rresp;
  endtask : rd
  task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(n, e, val);
  endtask : rchk
  task automatic rxc(input logic [7:0] s, input logic [7:0] d);
    rchk("status", ASR_OFF_RX_STATUS_CONTROL, s);
    rchk("data", ASR_OFF_RECEIVE_DATA, d);
  endtask : rxc
  task automatic frame(input logic [8:0] d, input logic nine, input logic stop);
    u_line.send(d, nine, stop);
    repeat (4) @(posedge clock);
  endtask : frame
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    #200000;
    errors++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        wr(rows[i].a, rows[i].d);
        chk("bresp", {6'h0, rows[i].r}, {6'h0, resp});
      end
      rd(rows[i].a);
      chk("rdata", rows[i].e, val);
      chk("rresp", {6'h0, rows[i].r}, {6'h0, resp});
    end
    $display("register rows done");
    wr(ASR_OFF_BAUD_DIVISOR_LOW, 8'h00);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h90);
    wr(ASR_OFF_TX_STATUS_CONTROL, 8'h24);
    rchk("tx flag", ASR_OFF_FLAGS, 8'h01);
    wr(ASR_OFF_INTERRUPT_CONTROL, 8'hD0);
    repeat (2) @(posedge clock);
    chk("tx irq", 8'h01, {7'h0, irq});
    wr(ASR_OFF_INTERRUPT_CONTROL, 8'hE0);
    wr(ASR_OFF_BAUD_CONTROL, 8'h10);
    repeat (2) @(posedge clock);
    chk("tx pin", 8'h02, {6'h0, tx_oe, tx_out});
    chk("irq idle", 8'h00, {7'h0, irq});
    frame(9'h0A5, 1'h0, 1'h1);
    chk("rx irq", 8'h01, {7'h0, irq});
    rchk("pending", ASR_OFF_FLAGS, 8'h03);
    rxc(8'h90, 8'hA5);
    frame(9'h03C, 1'h0, 1'h0);
    rxc(8'h94, 8'h3C);
    u_line.glitch(100);
    repeat (30) @(posedge clock);
    rchk("glitch", ASR_OFF_FLAGS, 8'h01);
    $display("single frames done");
    frame(9'h011, 1'h0, 1'h1);
    frame(9'h022, 1'h0, 1'h1);
    frame(9'h033, 1'h0, 1'h1);
    rxc(8'h92, 8'h11);
    rchk("second", ASR_OFF_RECEIVE_DATA, 8'h22);
    frame(9'h044, 1'h0, 1'h1);
    rchk("locked", ASR_OFF_FLAGS, 8'h01);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h80);
    rchk("ovr clear", ASR_OFF_RX_STATUS_CONTROL, 8'h80);
    wr(ASR_OFF_BAUD_CONTROL, 8'h20);
    u_line.set_inv(1'h1);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h90);
    frame(9'h05A, 1'h0, 1'h1);
    rxc(8'h90, 8'h5A);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h80);
    wr(ASR_OFF_BAUD_CONTROL, 8'h00);
    u_line.set_inv(1'h0);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'hD0);
    frame(9'h1C3, 1'h1, 1'h1);
    rxc(8'hD1, 8'hC3);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h80);
    frame(9'h0F0, 1'h0, 1'h1);
    wr(ASR_OFF_RX_STATUS_CONTROL, 8'h90);
    rchk("rx off", ASR_OFF_FLAGS, 8'h01);
    wr(ASR_OFF_TRANSMIT_DATA, 8'h01);
    repeat (4) @(posedge clock);
    chk("tx start", 8'h02, {6'h0, tx_oe, tx_out});
    repeat (16) @(posedge clock);
    chk("tx lsb", 8'h03, {6'h0, tx_oe, tx_out});
    $display("fifo and mode cases done");
    wrap_up();
  end
endmodule : test_asr_serial_port
`default_nettype wire

// >>> hw/asr_pkg.sv
// shared constants and types for the asynchronous serial port block
// assumes one system clock and an AXI4-Lite master with 32-bit data
package asr_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [5:0] ASR_OFF_BAUD_CONTROL = 6'h00;
  localparam logic [5:0] ASR_OFF_RX_STATUS_CONTROL = 6'h04;
  localparam logic [5:0] ASR_OFF_BAUD_DIVISOR_LOW = 6'h08;
  localparam logic [5:0] ASR_OFF_BAUD_DIVISOR_HIGH = 6'h0C;
  localparam logic [5:0] ASR_OFF_TRANSMIT_DATA = 6'h10;
  localparam logic [5:0] ASR_OFF_TX_STATUS_CONTROL = 6'h14;
  localparam logic [5:0] ASR_OFF_RECEIVE_DATA = 6'h18;
  localparam logic [5:0] ASR_OFF_INTERRUPT_CONTROL = 6'h1C;
  localparam logic [5:0] ASR_OFF_FLAGS = 6'h20;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // baud_control
  localparam int ASR_BC_RX_IDLE = 6;
  localparam int ASR_BC_RX_POLARITY = 5;
  localparam int ASR_BC_TX_POLARITY = 4;
  localparam int ASR_BC_WIDE_DIVISOR = 3;
  // receive_status_control
  localparam int ASR_RS_PORT_ENABLE = 7;
  localparam int ASR_RS_NINE_BIT_RX = 6;
  localparam int ASR_RS_CONT_RX_ENABLE = 4;
  localparam int ASR_RS_FRAMING_ERROR = 2;
  localparam int ASR_RS_OVERRUN_ERROR = 1;
  localparam int ASR_RS_RX_NINTH_BIT = 0;
  // transmit_status_control
  localparam int ASR_TS_NINE_BIT_TX = 6;
  localparam int ASR_TS_TX_ENABLE = 5;
  localparam int ASR_TS_SYNC_MODE = 4;
  localparam int ASR_TS_HIGH_SPEED = 2;
  localparam int ASR_TS_SHIFTER_EMPTY = 1;
  localparam int ASR_TS_TX_NINTH_BIT = 0;
  // interrupt_control
  localparam int ASR_IC_GLOBAL_ENABLE = 7;
  localparam int ASR_IC_PERIPH_ENABLE = 6;
  localparam int ASR_IC_RX_INT_ENABLE = 5;
  localparam int ASR_IC_TX_INT_ENABLE = 4;
  // flags
  localparam int ASR_FL_RX_PENDING = 1;
  localparam int ASR_FL_TX_EMPTY = 0;

  // ****************************************************************
  // reset values, counts and bus response codes
  // ****************************************************************
  localparam logic [7:0] ASR_RST_BYTE = 8'h00;
  localparam logic [3:0] ASR_OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] ASR_START_CHECK = 4'h7;
  localparam logic [3:0] ASR_FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] ASR_FRAME_BITS_9 = 4'hB;
  localparam logic [1:0] ASR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASR_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {ASR_RX_IDLE, ASR_RX_START, ASR_RX_DATA, ASR_RX_STOP} asr_rx_state_t;

  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } asr_rx_char_t;

endpackage : asr_pkg

// >>> hw/asr_serial_port.sv
// asynchronous serial port: AXI4-Lite register file, receiver with
// 16x oversampling and two-entry FIFO, simple transmitter, interrupt request
// assumes RX_PIN is asynchronous to CLOCK; bus master follows AXI4-Lite
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module asr_serial_port
  import asr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [5:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [5:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic RX_PIN,
  output logic TX_PIN_OUT,
  output logic TX_PIN_OE,
  output logic INT_REQUEST
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic aw_held_q, w_held_q, wr_do;
  logic [5:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic ar_fire;
  logic [31:0] rd_word;
  logic rd_hit;
  // control bits
  logic rx_pol_q, tx_pol_q, wide_div_q, high_speed_q;
  logic port_en_q, rx9_q, continuous_receive_enable_q, tx9_q, transmit_enable_q, sync_q, tx_ninth_q;
  logic gie_q, peie_q, rcie_q, txie_q;
  logic [7:0] div_lo_q, div_hi_q;
  // baud generator
  logic [17:0] baud_cnt_q, baud_period;
  logic tick_q;
  // receiver
  logic rx_meta_q, rx_sync_q, rx_prev_q, rx_line;
  asr_rx_state_t rx_state_q;
  logic [3:0] rx_tick_q, rx_bits_q;
  logic [2:0] rx_samp_q;
  logic [8:0] rx_shift_q;
  logic rx_on, majority, overrun_q, push, pop;
  asr_rx_char_t fifo_mem_q [2];
  asr_rx_char_t push_char, top_char;
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] fifo_cnt_q;
  logic rx_pending;
  // transmitter
  logic [10:0] tsr_q;
  logic [3:0] tx_tick_q, tx_bits_q;
  logic tx_busy_q, tx_buf_full_q, tx_on, tx_empty, tx_load_wr;
  logic [8:0] tx_buf_q;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_do = aw_held_q && w_held_q && !BVALID;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_byte_q <= ASR_RST_BYTE;
      w_lane_q <= 1'b0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= ASR_RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_held_q <= 1'b1;
        w_byte_q <= WDATA[7:0];
        w_lane_q <= WSTRB[0];
        WREADY <= 1'b0;
      end
      if (wr_do)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr_q > ASR_OFF_FLAGS || aw_addr_q[1:0] != 2'h0) ?
                 ASR_RESP_SLVERR : ASR_RESP_OKAY;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_pol_q <= 1'b0;
      tx_pol_q <= 1'b0;
      wide_div_q <= 1'b0;
      high_speed_q <= 1'b0;
      port_en_q <= 1'b0;
      rx9_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
      tx9_q <= 1'b0;
      transmit_enable_q <= 1'b0;
      sync_q <= 1'b0;
      tx_ninth_q <= 1'b0;
      gie_q <= 1'b0;
      peie_q <= 1'b0;
      rcie_q <= 1'b0;
      txie_q <= 1'b0;
      div_lo_q <= ASR_RST_BYTE;
      div_hi_q <= ASR_RST_BYTE;
    end
    else if (wr_do && w_lane_q)
    begin
      case (aw_addr_q)
        ASR_OFF_BAUD_CONTROL:
        begin
          rx_pol_q <= w_byte_q[ASR_BC_RX_POLARITY];
          tx_pol_q <= w_byte_q[ASR_BC_TX_POLARITY];
          wide_div_q <= w_byte_q[ASR_BC_WIDE_DIVISOR];
        end
        ASR_OFF_RX_STATUS_CONTROL:
        begin
          port_en_q <= w_byte_q[ASR_RS_PORT_ENABLE];
          rx9_q <= w_byte_q[ASR_RS_NINE_BIT_RX];
          continuous_receive_enable_q <= w_byte_q[ASR_RS_CONT_RX_ENABLE];
        end
        ASR_OFF_BAUD_DIVISOR_LOW: div_lo_q <= w_byte_q;
        ASR_OFF_BAUD_DIVISOR_HIGH: div_hi_q <= w_byte_q;
        ASR_OFF_TX_STATUS_CONTROL:
        begin
          tx9_q <= w_byte_q[ASR_TS_NINE_BIT_TX];
          transmit_enable_q <= w_byte_q[ASR_TS_TX_ENABLE];
          sync_q <= w_byte_q[ASR_TS_SYNC_MODE];
          high_speed_q <= w_byte_q[ASR_TS_HIGH_SPEED];
          tx_ninth_q <= w_byte_q[ASR_TS_TX_NINTH_BIT];
        end
        ASR_OFF_INTERRUPT_CONTROL:
        begin
          gie_q <= w_byte_q[ASR_IC_GLOBAL_ENABLE];
          peie_q <= w_byte_q[ASR_IC_PERIPH_ENABLE];
          rcie_q <= w_byte_q[ASR_IC_RX_INT_ENABLE];
          txie_q <= w_byte_q[ASR_IC_TX_INT_ENABLE];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign ar_fire = ARVALID && ARREADY;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ARADDR)
      ASR_OFF_BAUD_CONTROL:
      begin
        rd_word[ASR_BC_RX_IDLE] = (rx_state_q == ASR_RX_IDLE);
        rd_word[ASR_BC_RX_POLARITY] = rx_pol_q;
        rd_word[ASR_BC_TX_POLARITY] = tx_pol_q;
        rd_word[ASR_BC_WIDE_DIVISOR] = wide_div_q;
      end
      ASR_OFF_RX_STATUS_CONTROL:
      begin
        rd_word[ASR_RS_PORT_ENABLE] = port_en_q;
        rd_word[ASR_RS_NINE_BIT_RX] = rx9_q;
        rd_word[ASR_RS_CONT_RX_ENABLE] = continuous_receive_enable_q;
        rd_word[ASR_RS_FRAMING_ERROR] = (fifo_cnt_q != 2'h0) && top_char.framing_error;
        rd_word[ASR_RS_OVERRUN_ERROR] = overrun_q;
        rd_word[ASR_RS_RX_NINTH_BIT] = (fifo_cnt_q != 2'h0) && top_char.ninth;
      end
      ASR_OFF_BAUD_DIVISOR_LOW: rd_word[7:0] = div_lo_q;
      ASR_OFF_BAUD_DIVISOR_HIGH: rd_word[7:0] = div_hi_q;
      ASR_OFF_TRANSMIT_DATA: rd_word[7:0] = tx_buf_q[7:0];
      ASR_OFF_TX_STATUS_CONTROL:
      begin
        rd_word[ASR_TS_NINE_BIT_TX] = tx9_q;
        rd_word[ASR_TS_TX_ENABLE] = transmit_enable_q;
        rd_word[ASR_TS_SYNC_MODE] = sync_q;
        rd_word[ASR_TS_HIGH_SPEED] = high_speed_q;
        rd_word[ASR_TS_SHIFTER_EMPTY] = !tx_busy_q;
        rd_word[ASR_TS_TX_NINTH_BIT] = tx_ninth_q;
      end
      // the FIFO itself is never addressable, only its head
      ASR_OFF_RECEIVE_DATA: rd_word[7:0] = (fifo_cnt_q != 2'h0) ? top_char.data : 8'h00;
      ASR_OFF_INTERRUPT_CONTROL:
      begin
        rd_word[ASR_IC_GLOBAL_ENABLE] = gie_q;
        rd_word[ASR_IC_PERIPH_ENABLE] = peie_q;
        rd_word[ASR_IC_RX_INT_ENABLE] = rcie_q;
        rd_word[ASR_IC_TX_INT_ENABLE] = txie_q;
      end
      ASR_OFF_FLAGS:
      begin
        rd_word[ASR_FL_RX_PENDING] = rx_pending;
        rd_word[ASR_FL_TX_EMPTY] = tx_empty;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= ASR_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= rd_hit ? ASR_RESP_OKAY : ASR_RESP_SLVERR;
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ****************************************************************
  // baud generator, one tick per sixteenth of a bit
  // ****************************************************************
  // x64 prescale stretches the tick by four; x4 mode is run as x16
  always_comb
  begin
    baud_period = wide_div_q ? {2'b00, div_hi_q, div_lo_q} : {10'h000, div_lo_q};
    if (!wide_div_q && !high_speed_q)
      baud_period = {baud_period[15:0], 2'b11};
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      baud_cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end
    else if (!port_en_q || baud_cnt_q >= baud_period)
    begin
      baud_cnt_q <= 18'h00000;
      tick_q <= port_en_q;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 18'h00001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // receive line synchroniser and polarity
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_meta_q <= RX_PIN;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_line;
    end
  end

  assign rx_line = rx_sync_q ^ rx_pol_q;
  assign rx_on = port_en_q && continuous_receive_enable_q && !sync_q;
  assign majority = (rx_samp_q[0] & rx_samp_q[1]) | (rx_samp_q[1] & rx_samp_q[2]) |
                    (rx_samp_q[0] & rx_samp_q[2]);

  // ****************************************************************
  // receive state machine
  // ****************************************************************
  // tick count restarts at the start-bit centre, so samples 13..15 fall just before each centre
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_state_q <= ASR_RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bits_q <= 4'h0;
      rx_samp_q <= 3'b111;
      rx_shift_q <= 9'h000;
      push <= 1'b0;
      push_char <= '0;
    end
    else
    begin
      push <= 1'b0;
      if (tick_q)
        rx_samp_q <= {rx_samp_q[1:0], rx_line};
      if (!rx_on)
        rx_state_q <= ASR_RX_IDLE;
      else
      begin
        case (rx_state_q)
          ASR_RX_IDLE:
          begin
            rx_tick_q <= 4'h0;
            if (rx_prev_q && !rx_line && !overrun_q)
              rx_state_q <= ASR_RX_START;
          end
          ASR_RX_START:
          begin
            if (tick_q)
            begin
              rx_tick_q <= rx_tick_q + 4'h1;
              if (rx_tick_q == ASR_START_CHECK)
              begin
                rx_tick_q <= 4'h0;
                rx_bits_q <= 4'h0;
                rx_state_q <= rx_line ? ASR_RX_IDLE : ASR_RX_DATA;
              end
            end
          end
          ASR_RX_DATA:
          begin
            if (tick_q)
            begin
              rx_tick_q <= rx_tick_q + 4'h1;
              if (rx_tick_q == ASR_OVERSAMPLE_LAST)
              begin
                // lsb arrives first, so shift in from the top
                if (rx9_q)
                  rx_shift_q <= {majority, rx_shift_q[8:1]};
                else
                  rx_shift_q <= {1'b0, majority, rx_shift_q[7:1]};
                rx_bits_q <= rx_bits_q + 4'h1;
                if (rx_bits_q == (rx9_q ? 4'h8 : 4'h7))
                  rx_state_q <= ASR_RX_STOP;
              end
            end
          end
          ASR_RX_STOP:
          begin
            if (tick_q)
            begin
              rx_tick_q <= rx_tick_q + 4'h1;
              if (rx_tick_q == ASR_OVERSAMPLE_LAST)
              begin
                push <= 1'b1;
                push_char.framing_error <= !majority;
                push_char.ninth <= rx_shift_q[8];
                push_char.data <= rx_shift_q[7:0];
                rx_state_q <= ASR_RX_IDLE;
              end
            end
          end
          default: rx_state_q <= ASR_RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // two-entry receive FIFO and overrun
  // ****************************************************************
  assign top_char = fifo_mem_q[rd_ptr_q];
  assign pop = ar_fire && ARADDR == ASR_OFF_RECEIVE_DATA && fifo_cnt_q != 2'h0;
  assign rx_pending = rx_on && fifo_cnt_q != 2'h0;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      fifo_mem_q[0] <= '0;
      fifo_mem_q[1] <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fifo_cnt_q <= 2'h0;
      overrun_q <= 1'b0;
    end
    else if (!port_en_q)
    begin
      // port disable is the port reset: FIFO, framing and overrun all clear
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fifo_cnt_q <= 2'h0;
      overrun_q <= 1'b0;
    end
    else
    begin
      // a pop in the same cycle frees the slot, so that push is not an overrun
      if (push && (fifo_cnt_q != 2'h2 || pop))
      begin
        fifo_mem_q[wr_ptr_q] <= push_char;
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= !rd_ptr_q;
      if (push && fifo_cnt_q == 2'h2 && !pop)
        overrun_q <= 1'b1;
      else if (!continuous_receive_enable_q)
        overrun_q <= 1'b0;
      if (push && !pop && fifo_cnt_q != 2'h2)
        fifo_cnt_q <= fifo_cnt_q + 2'h1;
      else if (pop && !push)
        fifo_cnt_q <= fifo_cnt_q - 2'h1;
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  assign tx_on = port_en_q && transmit_enable_q && !sync_q;
  assign tx_empty = tx_on && !tx_buf_full_q;
  assign tx_load_wr = wr_do && w_lane_q && aw_addr_q == ASR_OFF_TRANSMIT_DATA;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      tsr_q <= 11'h7FF;
      tx_busy_q <= 1'b0;
      tx_tick_q <= 4'h0;
      tx_bits_q <= 4'h0;
      tx_buf_q <= 9'h000;
      tx_buf_full_q <= 1'b0;
    end
    else if (!tx_on)
    begin
      tx_busy_q <= 1'b0;
      tx_buf_full_q <= 1'b0;
      tsr_q <= 11'h7FF;
    end
    else
    begin
      // a write while the buffer is still occupied is dropped
      // a buffer handing over to an idle shifter this cycle is free for the write
      if (tx_load_wr && (!tx_buf_full_q || !tx_busy_q))
      begin
        tx_buf_q <= {tx_ninth_q, w_byte_q};
        tx_buf_full_q <= 1'b1;
      end
      if (tx_busy_q && tick_q)
      begin
        tx_tick_q <= tx_tick_q + 4'h1;
        if (tx_tick_q == ASR_OVERSAMPLE_LAST)
        begin
          tsr_q <= {1'b1, tsr_q[10:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'h1)
            tx_busy_q <= 1'b0;
        end
      end
      else if (!tx_busy_q && tx_buf_full_q)
      begin
        tsr_q <= tx9_q ? {1'b1, tx_buf_q, 1'b0} : {2'b11, tx_buf_q[7:0], 1'b0};
        tx_bits_q <= tx9_q ? ASR_FRAME_BITS_9 : ASR_FRAME_BITS_8;
        tx_tick_q <= 4'h0;
        tx_busy_q <= 1'b1;
        tx_buf_full_q <= tx_load_wr;
      end
    end
  end

  // ****************************************************************
  // pin and interrupt outputs
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      TX_PIN_OUT <= 1'b1;
      TX_PIN_OE <= 1'b0;
      INT_REQUEST <= 1'b0;
    end
    else
    begin
      TX_PIN_OUT <= (tx_busy_q ? tsr_q[0] : 1'b1) ^ tx_pol_q;
      TX_PIN_OE <= port_en_q;
      INT_REQUEST <= gie_q && peie_q &&
                     ((rcie_q && rx_pending) || (txie_q && tx_empty));
    end
  end

endmodule : asr_serial_port

`default_nettype wire
